// >>> verilog/prc_pkg.sv
// Constants, address map and word layout of the parameter range checker
package prc_pkg;

  // Expansion words start at this word offset (100)
  localparam logic [6:0] EXP_OFS = 7'h64;
  // First word of unit 0 parameter area (20000)
  localparam logic [15:0] AREA_ORIGIN = 16'h4e20;
  // Words allotted per unit number (100)
  localparam logic [15:0] AREA_STRIDE = 16'h0064;
  // Highest legal unit number (95)
  localparam logic [6:0] UNIT_LAST = 7'h5f;
  // Largest legal value of a checked parameter word
  localparam logic [15:0] PARAM_MAX = 16'h2710;

  // Word layout inside the parameter area
  localparam logic [6:0] G1_HI = 7'h03; // Continuous group, words 0..3
  localparam logic [6:0] G2_HI = 7'h07; // Initial group, words 4..7
  localparam logic [6:0] G3_HI = 7'h65; // Expansion continuous, 100..101
  localparam logic [6:0] G4_HI = 7'h67; // Expansion initial, 102..103
  // Held words: 8 base words then 4 expansion words
  localparam int NSLOT = 12;
  localparam int NBASE = 8;

  // Byte addresses on the register bus
  localparam logic [11:0] ADR_PARAM_END = 12'h0200;
  localparam logic [11:0] ADR_RSTFLAG0 = 12'h0200;
  localparam logic [11:0] ADR_RSTFLAG2 = 12'h0208;
  localparam logic [11:0] ADR_CMD = 12'h020c;
  localparam logic [11:0] ADR_STATUS = 12'h0210;
  localparam logic [11:0] ADR_ERROFS = 12'h0214;
  localparam logic [11:0] ADR_AREABASE = 12'h0218;

  // Field positions
  localparam int CMD_RESTART_BIT = 0;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam int STAT_LOAD_BIT = 2;

  // Unit start-up state
  typedef enum logic [1:0] {ST_SKIP, ST_LOAD, ST_RUN, ST_HALT} prc_state_e;

  // Word is range checked
  function automatic logic is_checked(input logic [6:0] a);
    return (a <= G2_HI) || (a >= EXP_OFS && a <= G4_HI);
  endfunction

  // Word belongs to a continuously refreshed group
  function automatic logic is_cont(input logic [6:0] a);
    return (a <= G1_HI) || (a >= EXP_OFS && a <= G3_HI);
  endfunction

endpackage

// >>> verilog/prc_scan_if.sv
// Scan path between the loader core and the range checker
`timescale 1ns/1ps
interface prc_scan_if;
  logic scan_en;          // Read port free for the scanner
  logic [6:0] scan_addr;  // Word being fetched
  logic [15:0] rd_data;   // Word read back, one cycle later
  logic vld;              // rd_data holds scanned word vaddr
  logic [6:0] vaddr;      // Word offset of rd_data
  logic sweep_done;       // One-cycle pulse after last word
  logic sweep_err;        // Sweep saw an out-of-range word
  logic [6:0] sweep_ofs;  // Lowest bad offset, 0 when none
  logic cont_bad;         // Continuous word out of range

  modport chk (input scan_en, rd_data, output scan_addr, vld, vaddr,
               sweep_done, sweep_err, sweep_ofs, cont_bad);
  modport ctl (output scan_en, rd_data, input scan_addr, vld, vaddr,
               sweep_done, sweep_err, sweep_ofs, cont_bad);
endinterface

// >>> verilog/prc_word_mem.sv
// Parameter word memory with one write and one registered read port
`timescale 1ns/1ps
module prc_word_mem #(
  parameter int DW = 16,
  parameter int AW = 7
) (
  input wire logic hclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  // Storage, no reset: contents come from the host
  logic [DW-1:0] mem [2**AW];

  // Write port
  always_ff @(posedge hclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read, fresh write forwarded
  always_ff @(posedge hclk) begin
    if (we && waddr == raddr) begin
      rdata <= wdata;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule // prc_word_mem

// >>> verilog/prc_range_chk.sv
// Range checker sweeping the parameter area word by word
`timescale 1ns/1ps
module prc_range_chk (
  input wire logic hclk,
  input wire logic hresetn,
  prc_scan_if.chk sif
);
  logic [6:0] ptr_q;    // Next word to fetch
  logic vld_q;          // Fetch issued last cycle
  logic [6:0] vaddr_q;  // Word of that fetch
  logic found_q;        // Error seen this sweep
  logic [6:0] ofs_q;    // First bad word this sweep
  logic cbad_q;         // Continuous error this sweep
  logic done_q;
  logic err_q;
  logic [6:0] eofs_q;
  logic cbad_out_q;

  // Current word status
  wire bad = vld_q && prc_pkg::is_checked(vaddr_q) &&
             sif.rd_data > prc_pkg::PARAM_MAX;
  wire last = vld_q && vaddr_q == 7'h7f;

  assign sif.scan_addr = ptr_q;
  assign sif.vld = vld_q;
  assign sif.vaddr = vaddr_q;
  assign sif.sweep_done = done_q;
  assign sif.sweep_err = err_q;
  assign sif.sweep_ofs = eofs_q;
  assign sif.cont_bad = cbad_out_q;

  // Fetch pointer, stalls while the bus owns the port
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ptr_q <= 7'h00;
      vld_q <= 1'b0;
      vaddr_q <= 7'h00;
    end else begin
      vld_q <= sif.scan_en;
      vaddr_q <= ptr_q;
      if (sif.scan_en) begin
        ptr_q <= ptr_q + 7'h01;
      end
    end
  end

  // Sweep result, words scanned lowest first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      found_q <= 1'b0;
      ofs_q <= 7'h00;
      cbad_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
      eofs_q <= 7'h00;
      cbad_out_q <= 1'b0;
    end else if (last) begin
      done_q <= 1'b1;
      err_q <= found_q | bad;
      eofs_q <= found_q ? ofs_q : 7'h00;
      cbad_out_q <= cbad_q | (bad & prc_pkg::is_cont(vaddr_q));
      found_q <= 1'b0;
      cbad_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (bad && !found_q) begin
        found_q <= 1'b1;
        ofs_q <= vaddr_q;
      end
      if (bad && prc_pkg::is_cont(vaddr_q)) begin
        cbad_q <= 1'b1;
      end
    end
  end
endmodule // prc_range_chk

// >>> verilog/prc_param_loader.sv
// Parameter range check and restart control with an AHB-Lite slave
//
// Overview of operation
// - Error lamp lit on any bad word
// - Report lowest bad word offset
// - Expansion words report offset 100 upward
// - Area start is 20000 plus unit times 100
// - Initial words applied only at restart
// - Restart flag rising edge restarts unit
// - Unit 00..95 selects flag and area
// - Restart instruction acts like controller reset
// - Error at restart keeps unit halted
// - Corrected error reports zero or next offset
`timescale 1ns/1ps
module prc_param_loader #(
  parameter int DW = 16,
  parameter int AW = 7
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [6:0] unit_number_pin,
  output logic config_error_lamp,
  output logic run_lamp,
  output logic [prc_pkg::NSLOT*DW-1:0] param_active,
  output logic [15:0] range_error_offset
);

  // Bus pipeline
  logic wr_q;           // Write data phase
  logic rd_q;           // Read data phase
  logic [11:0] addr_q;  // Address of the data phase
  logic rdy_q;          // Drives hreadyout
  logic [31:0] rdata_q; // Drives hrdata
  logic resp_q;         // Always OKAY

  // Restart flags, one bit per unit number
  logic [31:0] flag_q [3];
  logic flag_prev_q;    // Own flag, last cycle

  // Unit number strap
  logic [6:0] un_s1_q;
  logic [6:0] un_s2_q;
  logic [6:0] unit_q;
  logic [15:0] area_base_q;

  // Start-up state and indicators
  prc_pkg::prc_state_e state_q;
  prc_pkg::prc_state_e state_d;
  logic err_lamp_q;
  logic run_q;
  logic [15:0] eofs_q;

  // Words seen by the scanner and words in use
  logic [DW-1:0] stage_q [prc_pkg::NSLOT];
  logic [DW-1:0] act_q [prc_pkg::NSLOT];

  // Memory read data
  logic [DW-1:0] mem_rdata;

  prc_scan_if sif ();

  // Address phase accepted this cycle
  wire acc = hsel && htrans[1] && hready;
  wire acc_rd = acc && !hwrite;
  // Read of a parameter word steals the memory read port
  wire mem_rd_go = acc_rd && haddr < prc_pkg::ADR_PARAM_END;
  wire [AW-1:0] mem_raddr = mem_rd_go ? haddr[AW+1:2] : sif.scan_addr;

  // Write decode, data phase
  wire wr_param = wr_q && addr_q < prc_pkg::ADR_PARAM_END;
  wire wr_flag = wr_q && addr_q >= prc_pkg::ADR_RSTFLAG0 &&
                 addr_q <= prc_pkg::ADR_RSTFLAG2;
  wire wr_cmd = wr_q && addr_q == prc_pkg::ADR_CMD;
  wire instr_go = wr_cmd && hwdata[prc_pkg::CMD_RESTART_BIT];

  // own flag picked by unit number
  wire [95:0] flags_all = {flag_q[2], flag_q[1], flag_q[0]};
  wire flag_own = (unit_q <= prc_pkg::UNIT_LAST) ? flags_all[unit_q] : 1'b0;
  // restart on 0 to 1 change
  wire flag_rise = flag_own && !flag_prev_q;
  wire restart_req = flag_rise || instr_go;

  // Read data selection, data phase
  wire [31:0] stat_word = {29'h0000_0000,
                           state_q == prc_pkg::ST_LOAD ||
                           state_q == prc_pkg::ST_SKIP,
                           err_lamp_q, run_q};
  logic [31:0] rd_sel;
  always_comb begin
    rd_sel = 32'h0000_0000;
    if (addr_q < prc_pkg::ADR_PARAM_END) begin
      rd_sel = {{(32-DW){1'b0}}, mem_rdata};
    end else if (addr_q >= prc_pkg::ADR_RSTFLAG0 &&
                 addr_q <= prc_pkg::ADR_RSTFLAG2) begin
      rd_sel = flag_q[addr_q[3:2]];
    end else if (addr_q == prc_pkg::ADR_STATUS) begin
      rd_sel = stat_word;
    end else if (addr_q == prc_pkg::ADR_ERROFS) begin
      rd_sel = {16'h0000, eofs_q};
    end else if (addr_q == prc_pkg::ADR_AREABASE) begin
      rd_sel = {16'h0000, area_base_q};
    end
  end

  // Memory and checker wiring
  // Parameter word reads win the single read port; the sweep simply pauses,
  // so heavy read traffic stretches the time between lamp updates
  assign sif.scan_en = !mem_rd_go;
  assign sif.rd_data = mem_rdata;

  prc_word_mem #(
    .DW(DW),
    .AW(AW)
  ) u_mem (
    .hclk(hclk),
    .we(wr_param),
    .waddr(addr_q[AW+1:2]),
    .wdata(hwdata[DW-1:0]),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  prc_range_chk u_chk (
    .hclk(hclk),
    .hresetn(hresetn),
    .sif(sif)
  );

  // Bus phase tracking; reads take one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 12'h000;
      rdy_q <= 1'b1;
    end else if (rdy_q) begin
      // New address phase only while ready
      wr_q <= acc && hwrite;
      rd_q <= acc_rd;
      rdy_q <= !acc_rd;
      if (acc) begin
        addr_q <= haddr;
      end
    end else begin
      // Wait state over, read data now stands
      rdy_q <= 1'b1;
    end
  end

  // Read data register, loaded in the wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
      resp_q <= 1'b0;
    end else if (rd_q && !rdy_q) begin
      rdata_q <= rd_sel;
    end
  end

  // Restart flag words, host owned
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q[0] <= 32'h0000_0000;
      flag_q[1] <= 32'h0000_0000;
      flag_q[2] <= 32'h0000_0000;
      flag_prev_q <= 1'b0;
    end else begin
      if (wr_flag) begin
        flag_q[addr_q[3:2]] <= hwdata;
      end
      flag_prev_q <= flag_own;
    end
  end

  // Strap from the rotary switch, three stages
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      un_s1_q <= 7'h00;
      un_s2_q <= 7'h00;
      unit_q <= 7'h00;
    end else begin
      un_s1_q <= unit_number_pin;
      un_s2_q <= un_s1_q;
      unit_q <= un_s2_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      area_base_q <= prc_pkg::AREA_ORIGIN;
    end else begin
      area_base_q <= 16'(prc_pkg::AREA_ORIGIN +
                         16'(unit_q) * prc_pkg::AREA_STRIDE);
    end
  end

  // Start-up sequence: skip partial sweep, load one full sweep
  always_comb begin
    state_d = state_q;
    case (state_q)
      prc_pkg::ST_SKIP: begin
        // Sweep in flight may predate the restart
        if (sif.sweep_done) begin
          state_d = prc_pkg::ST_LOAD;
        end
      end
      prc_pkg::ST_LOAD: begin
        // refuse to start with an error
        if (sif.sweep_done) begin
          state_d = sif.sweep_err ? prc_pkg::ST_HALT : prc_pkg::ST_RUN;
        end
      end
      prc_pkg::ST_RUN,
      prc_pkg::ST_HALT: begin
        state_d = state_q;
      end
      default: begin
        state_d = prc_pkg::ST_SKIP;
      end
    endcase
    if (restart_req) begin
      state_d = prc_pkg::ST_SKIP;
    end
  end

  // State register and run indicator
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= prc_pkg::ST_SKIP;
      run_q <= 1'b0;
    end else begin
      state_q <= state_d;
      // run lamp only after a clean load
      run_q <= state_d == prc_pkg::ST_RUN;
    end
  end

  // Error lamp and offset follow every finished sweep
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_lamp_q <= 1'b0;
      eofs_q <= 16'h0000;
    end else if (sif.sweep_done) begin
      err_lamp_q <= sif.sweep_err;
      // expansion offsets already count from 100
      eofs_q <= {9'h000, sif.sweep_ofs};
    end
  end

  // Per held word: capture while scanning, apply per group
  for (genvar k = 0; k < prc_pkg::NSLOT; k++) begin : g_slot
    localparam logic [6:0] SLOT_ADR = (k < prc_pkg::NBASE) ? 7'(k) :
                                      7'(prc_pkg::EXP_OFS + 7'(k - 8));
    localparam bit CONT = prc_pkg::is_cont(SLOT_ADR);
    // Load completes cleanly this cycle
    wire load_ok = state_q == prc_pkg::ST_LOAD && sif.sweep_done &&
                   !sif.sweep_err && !restart_req;
    // continuous words only when all continuous words are in range
    wire run_ok = CONT && state_q == prc_pkg::ST_RUN &&
                  sif.sweep_done && !sif.cont_bad;

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        stage_q[k] <= '0;
      end else if (sif.vld && sif.vaddr == SLOT_ADR) begin
        stage_q[k] <= sif.rd_data;
      end
    end

    // initial words change only on load
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        act_q[k] <= '0;
      end else if (load_ok || run_ok) begin
        act_q[k] <= stage_q[k];
      end
    end

    assign param_active[k*DW +: DW] = act_q[k];
  end

  // Outputs
  assign hreadyout = rdy_q;
  assign hrdata = rdata_q;
  assign hresp = resp_q;
  assign config_error_lamp = err_lamp_q;
  assign run_lamp = run_q;
  assign range_error_offset = eofs_q;

  // Only word transfers are meaningful; size is not checked
  wire unused_ok = &{1'b0, hsize, htrans[0]};

endmodule // prc_param_loader

// >>> sim/prc_param_loader_assertions.sv
// Port-level checks of the parameter loader
`timescale 1ns/1ps
module prc_param_loader_assertions #(
  parameter int DW = 16,
  parameter int AW = 7
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic [6:0] unit_number_pin,
  input wire logic config_error_lamp,
  input wire logic run_lamp,
  input wire logic [prc_pkg::NSLOT*DW-1:0] param_active,
  input wire logic [15:0] range_error_offset
);
  // Transfer taken in an address phase
  wire take = hsel && htrans[1] && hready;
  wire [15:0] ofs = range_error_offset; // Short alias
  logic cmd_wr_q; // Data phase of a command write
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Mark the data phase that carries a command word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cmd_wr_q <= 1'b0;
    else if (hready) cmd_wr_q <= take && hwrite && haddr == prc_pkg::ADR_CMD;
  end
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("slave answered other than okay");
  chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not one wait cycle");
  chk_write_fast: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  chk_clear_zero: assert property (!config_error_lamp |-> ofs == 16'h0000)
    else $error("offset not zero with lamp dark");
  chk_ofs_checked: assert property (config_error_lamp |->
    ofs <= 16'h0007 || (ofs >= 16'h0064 && ofs <= 16'h0067))
    else $error("offset outside checked words");
  chk_start_clean: assert property ($rose(run_lamp) |-> !config_error_lamp)
    else $error("unit started with an error");
  chk_init_frozen: assert property (run_lamp && $past(run_lamp) |->
    $stable(param_active[127:64]) && $stable(param_active[191:160]))
    else $error("initial words changed while running");
  chk_err_keeps_run: assert property (
    $rose(config_error_lamp) && $past(run_lamp) |-> run_lamp)
    else $error("range error stopped a running unit");
  chk_cmd_restart: assert property (cmd_wr_q && hwdata[0] |-> ##[1:4] !run_lamp)
    else $error("restart instruction ignored");
endmodule // prc_param_loader_assertions

// >>> sim/prc_host_model.sv
// Host controller model driving the register bus
`timescale 1ns/1ps
module prc_host_model (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [11:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // Idle bus from time zero
  initial begin
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end
  // One word transfer; call right after a rising edge
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    htrans <= 2'h0;
    // Read phases carry changing junk, never stale data
    hwdata <= wr ? wd : ~hwdata;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    rd = hrdata;
  endtask
  // own flag bit, 0 then 1
  task automatic restart_flag(input int u);
    logic [11:0] a;
    logic [31:0] d;
    a = prc_pkg::ADR_RSTFLAG0 + 12'(4 * (u / 32));
    xfer(1'b1, a, 32'h0000_0000, d);
    xfer(1'b1, a, 32'h0000_0001 << (u % 32), d);
  endtask
  task automatic restart_cmd();
    logic [31:0] d;
    xfer(1'b1, prc_pkg::ADR_CMD, 32'h0000_0001, d);
  endtask
endmodule // prc_host_model

// >>> sim/prc_param_loader_tb.sv
// Self-checking bench for the parameter loader
`timescale 1ns/1ps
module prc_param_loader_tb;
  localparam int DW = 16;
  localparam int AW = 7;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, err, run;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [6:0] unit_number_pin;
  logic [prc_pkg::NSLOT*DW-1:0] param_active;
  logic [15:0] ofs, v, v2;
  integer seed = 78609; // Fixed seed, repeatable run
  int n_errors = 0;
  int checks_done = 0;
  int unit;
  prc_host_model prc_host_model_inst (.hclk(hclk), .hready(hreadyout),
    .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  prc_param_loader #(.DW(DW), .AW(AW)) prc_param_loader_inst (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .unit_number_pin(unit_number_pin), .config_error_lamp(err),
    .run_lamp(run), .param_active(param_active), .range_error_offset(ofs));
  // Free-running 100 MHz clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // Value compare
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  // Bus read compare
  task automatic rd_cmp(input logic [11:0] a, input logic [31:0] e);
    prc_host_model_inst.xfer(1'b0, a, 32'h0000_0000, rd);
    cmp("bus read", e, rd);
  endtask
  task automatic wr_word(input int i, input logic [15:0] d);
    prc_host_model_inst.xfer(1'b1, 12'(4 * i), {16'h0000, d}, rd);
  endtask
  // Word memory has no reset; zero the checked words before the load
  // sweep reads them, so slots never start out unknown
  task automatic init_words();
    for (int i = 0; i < 12; i++) begin
      wr_word(i < 8 ? i : i + 92, 16'h0000);
    end
  endtask
  function automatic logic [31:0] area_base(input int u);
    return 32'(20000 + u * 100);
  endfunction
  function automatic logic [31:0] slot(input int k);
    return {16'h0000, param_active[k*16 +: 16]};
  endfunction
  // Bounded wait for the run lamp
  task automatic wait_run(input logic lvl);
    int n;
    n = 0;
    while (run !== lvl && n < 2000) begin
      @(posedge hclk);
      n++;
    end
    cmp("run_lamp", 32'(lvl), 32'(run));
  endtask
  // Three full sweeps so lamp and offset are fresh
  task automatic settle();
    repeat (400) @(posedge hclk);
  endtask
  task automatic lamps(input logic e, input logic r, input logic [15:0] o);
    cmp("config_error_lamp", 32'(e), 32'(err));
    cmp("run_lamp", 32'(r), 32'(run));
    cmp("range_error_offset", 32'(o), 32'(ofs));
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Watchdog well past the expected run
  initial begin
    #400000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    hresetn = 1'b0;
    unit = $unsigned($random(seed)) % 96;
    unit_number_pin = 7'(unit);
    v = 16'($unsigned($random(seed)) % 10001);
    v2 = 16'($unsigned($random(seed)) % 10000 + 1);
    repeat (2) @(posedge hclk);
    lamps(1'b0, 1'b0, 16'h0000);
    hresetn <= 1'b1;
    @(posedge hclk);
    init_words();
    wait_run(1'b1);
    rd_cmp(prc_pkg::ADR_AREABASE, area_base(unit));
    rd_cmp(12'h21c, 32'h0000_0000);
    $display("test map done");
    wr_word(2, v);
    settle();
    cmp("slot 2", {16'h0000, v}, slot(2));
    wr_word(2, 16'h2711);
    wr_word(1, 16'hffff);
    settle();
    lamps(1'b1, 1'b1, 16'h0001);
    cmp("slot 2 kept", {16'h0000, v}, slot(2));
    wr_word(1, 16'h2710);
    settle();
    lamps(1'b1, 1'b1, 16'h0002);
    wr_word(2, 16'h0000);
    settle();
    lamps(1'b0, 1'b1, 16'h0000);
    $display("test refresh done");
    wr_word(5, v2);
    settle();
    cmp("slot 5 frozen", 32'h0000_0000, slot(5));
    prc_host_model_inst.restart_flag(unit);
    wait_run(1'b0);
    wait_run(1'b1);
    cmp("slot 5 loaded", {16'h0000, v2}, slot(5));
    $display("test restart done");
    wr_word(102, 16'h8000);
    wr_word(100, 16'h2711);
    prc_host_model_inst.restart_cmd();
    wait_run(1'b0);
    repeat (1000) @(posedge hclk);
    lamps(1'b1, 1'b0, 16'h0064);
    wr_word(100, 16'h0000);
    settle();
    lamps(1'b1, 1'b0, 16'h0066);
    wr_word(102, 16'h0000);
    prc_host_model_inst.restart_flag(unit);
    wait_run(1'b1);
    lamps(1'b0, 1'b1, 16'h0000);
    $display("test halt done");
    report_and_stop();
  end
endmodule // prc_param_loader_tb
bind prc_param_loader prc_param_loader_assertions #(.DW(DW), .AW(AW))
  chk_inst (.*);
